// ---- design/eirqfe_pkg.sv ----
package eirqfe_pkg;

  // Number of external inputs; vector slots 0..4 carry inputs 0,1,2,3,5
  localparam int NUM_IRQ = 5;
  localparam int SLOT_ZERO = 0;
  localparam int SLOT_ONE = 1;
  localparam int SLOT_TWO = 2;
  localparam int SLOT_THREE = 3;
  localparam int SLOT_FIVE = 4;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MODE = 10'h030;
  localparam logic [9:0] IDX_CTRL = 10'h037;
  localparam logic [9:0] IDX_ENABLE = 10'h03A;
  localparam logic [9:0] IDX_LATCH = 10'h03C;
  localparam logic [9:0] IDX_SELECT = 10'h03E;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam logic SELECT_RESET = 1'b0;
  localparam logic MODE_RESET = 1'b0;

  // Field positions outside the control struct
  localparam int EN_MASTER_BIT = 0;
  localparam int EN_FLAG_LSB = 1;
  localparam int LATCH_LSB = 1;
  localparam int SELECT_BIT = 0;
  localparam int MODE_SLOW_BIT = 0;

  // Clock rates: the high-frequency clock is pclk itself
  localparam longint PCLK_HZ = 100_000_000;
  localparam longint FC_HZ = 100_000_000;

  // Reject times in high-clock periods
  localparam longint REJ_ZERO_FIVE_FC = 2;
  localparam longint REJ_ONE_SHORT_FC = 15;
  localparam longint REJ_ONE_LONG_FC = 63;
  localparam longint REJ_TWO_THREE_FC = 7;
  // Reject time in low-clock periods (slow and sleep)
  localparam longint REJ_SLOW_FS = 1;

  // Thresholds in pclk cycles, rounded up
  localparam logic [6:0] THR_ZERO_FIVE =
    7'((REJ_ZERO_FIVE_FC * PCLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam logic [6:0] THR_ONE_SHORT =
    7'((REJ_ONE_SHORT_FC * PCLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam logic [6:0] THR_ONE_LONG =
    7'((REJ_ONE_LONG_FC * PCLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam logic [6:0] THR_TWO_THREE =
    7'((REJ_TWO_THREE_FC * PCLK_HZ + FC_HZ - 1) / FC_HZ);
  // Low-clock ticks: a pulse under one period holds at most one tick
  localparam logic [6:0] THR_SLOW = 7'(REJ_SLOW_FS + 1);

  // Control register layout
  typedef struct packed {
    logic noise_sel;
    logic pin_func;
    logic [1:0] rsv_hi;
    logic edge_three;
    logic edge_two;
    logic edge_one;
    logic rsv_lo;
  } eirqfe_ctrl_type;

endpackage

// ---- design/eirqfe_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
module eirqfe_filter
  import eirqfe_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and timing
  input wire logic pin,
  input wire logic tick,
  input wire logic [CNT_W-1:0] thresh,
  // Filtered level
  output logic level
);

  logic sync_a;
  logic sync_b;
  logic [CNT_W-1:0] cnt;

  if (CNT_W < 7) begin : g_bad_width
    $error("eirqfe_filter: counter too narrow for longest threshold");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // count stable samples of new level
  // short pulses never reach the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      level <= 1'b1;
    end else if (sync_b == level) begin
      cnt <= '0;
    end else if (tick) begin
      if (cnt + 1'b1 >= thresh) begin
        level <= sync_b;
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // level moves only once threshold reached
  chk_filter_count: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(level) |-> ($past(cnt) + 1'b1 >= $past(thresh)) && $past(tick)
  ) else $error("filter passed a level before threshold");

endmodule // eirqfe_filter
`default_nettype wire

// ---- design/eirqfe_top.sv ----
// Behaviour
// - Five external inputs, each filtered for short pulses before edge detection.
// - Inputs one to three choose edge; inputs zero and five use falling.
// - Shared pin is a port input whether its pin-function bit is set or clear.
// - Pin-function bit clear: falling edge never sets input-zero latch.
// - Fast clock: inputs zero, five reject under 2, accept 7 periods.
// - Fast clock: input one rejects under 15 or 63, accepts 49 or 193.
// - Fast clock: inputs two, three reject under 7, accept 25 periods.
// - Slow or sleep: reject under one low period, accept 3.5 periods.
// - Clean edge sets its latch within establishment time plus six low periods.
// - Noise select clear means 63 periods, set means 15 periods.
// - Edge-select bit clear selects rising, set selects falling.
// - New noise threshold applies within 64 high-clock periods.
// - Driving the shared pin as output may raise a spurious request.
// - Master enable clear blocks every maskable request regardless of flags.
// - Input three latches its external pin only while the selector picks it, else the timer.
`timescale 1ns/1ns
`default_nettype none
module eirqfe_top
  import eirqfe_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins, slots 0..4 are inputs 0,1,2,3,5
  input wire logic [NUM_IRQ-1:0] ext_irq_pins,
  input wire logic low_freq_clock,
  // Shared timer source for input three
  input wire logic timer_three_irq,
  // Port view of the shared pin and interrupt out
  output logic shared_port_bit,
  output logic irq
);

  eirqfe_ctrl_type ext_irq_control;
  logic [7:0] irq_enable_reg;
  logic [NUM_IRQ-1:0] latch;
  logic shared_source_selector;
  logic slow_mode;
  logic [2:0] low_sync;
  logic low_tick;
  logic [NUM_IRQ-1:0] filt;
  logic [NUM_IRQ-1:0] filt_q;
  logic [NUM_IRQ-1:0] rise;
  logic [NUM_IRQ-1:0] fall;
  logic [NUM_IRQ-1:0] hit;
  logic [NUM_IRQ-1:0] clr;
  logic [CNT_W-1:0] thr [NUM_IRQ];
  logic master_irq_enable;
  logic [NUM_IRQ-1:0] enable_flags;
  logic setup;
  logic access_ok;
  logic wr_en;
  logic [9:0] idx;
  logic mapped;
  logic [31:0] next_prdata;

  if (CNT_W < 7) begin : g_bad_width
    $error("eirqfe_top: counter too narrow for longest threshold");
  end

  assign master_irq_enable = irq_enable_reg[EN_MASTER_BIT];
  assign enable_flags = irq_enable_reg[EN_FLAG_LSB +: NUM_IRQ];

  // low clock sampled twice, then edge taken as a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_sync <= 3'h0;
    end else begin
      low_sync <= {low_sync[1:0], low_freq_clock};
    end
  end
  assign low_tick = low_sync[1] & ~low_sync[2];

  always_comb begin
    if (slow_mode) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        thr[i] = CNT_W'(THR_SLOW);
      end
    end else begin
      thr[SLOT_ZERO] = CNT_W'(THR_ZERO_FIVE);
      thr[SLOT_FIVE] = CNT_W'(THR_ZERO_FIVE);
      thr[SLOT_ONE] = ext_irq_control.noise_sel ? CNT_W'(THR_ONE_SHORT)
                                                : CNT_W'(THR_ONE_LONG);
      thr[SLOT_TWO] = CNT_W'(THR_TWO_THREE);
      thr[SLOT_THREE] = CNT_W'(THR_TWO_THREE);
    end
  end

  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_filt
    eirqfe_filter #(.CNT_W(CNT_W)) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_irq_pins[g]),
      .tick(slow_mode ? low_tick : 1'b1),
      .thresh(thr[g]),
      .level(filt[g])
    );
  end

  // Previous filtered level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= '1;
    end else begin
      filt_q <= filt;
    end
  end
  assign rise = filt & ~filt_q;
  assign fall = ~filt & filt_q;

  // fixed falling edge on zero and five
  // edge select: clear rising, set falling
  // input zero gated by pin function
  // input three follows the source selector
  always_comb begin
    hit[SLOT_ZERO] = fall[SLOT_ZERO] & ext_irq_control.pin_func;
    hit[SLOT_FIVE] = fall[SLOT_FIVE];
    hit[SLOT_ONE] = ext_irq_control.edge_one ? fall[SLOT_ONE]
                                             : rise[SLOT_ONE];
    hit[SLOT_TWO] = ext_irq_control.edge_two ? fall[SLOT_TWO]
                                             : rise[SLOT_TWO];
    hit[SLOT_THREE] = shared_source_selector ? timer_three_irq
      : (ext_irq_control.edge_three ? fall[SLOT_THREE]
                                    : rise[SLOT_THREE]);
  end

  // shared pin read back as a port bit
  // pin fed straight in, so own output changes may trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_port_bit <= 1'b1;
    end else begin
      shared_port_bit <= filt_q[SLOT_ZERO];
    end
  end

  // APB phase decode
  assign setup = psel & ~penable;
  assign access_ok = psel & penable & pready;
  assign wr_en = access_ok & pwrite & ~pslverr;
  assign idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
    (idx == IDX_MODE || idx == IDX_CTRL || idx == IDX_ENABLE ||
     idx == IDX_LATCH || idx == IDX_SELECT);
  assign clr = (wr_en && idx == IDX_LATCH) ?
    pwdata[LATCH_LSB +: NUM_IRQ] : '0;

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (idx)
      IDX_MODE: next_prdata[MODE_SLOW_BIT] = slow_mode;
      IDX_CTRL: next_prdata[7:0] = ext_irq_control;
      IDX_ENABLE: next_prdata[7:0] = irq_enable_reg;
      IDX_LATCH: next_prdata[LATCH_LSB +: NUM_IRQ] = latch;
      IDX_SELECT: next_prdata[SELECT_BIT] = shared_source_selector;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Bus answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= mapped && !pwrite ? next_prdata : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register writes; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_control <= CTRL_RESET;
    end else if (wr_en && idx == IDX_CTRL) begin
      ext_irq_control <= pwdata[7:0] & 8'hCE;
    end
  end

  // Enable, selector and clock mode writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= ENABLE_RESET;
      shared_source_selector <= SELECT_RESET;
      slow_mode <= MODE_RESET;
    end else if (wr_en) begin
      if (idx == IDX_ENABLE) begin
        irq_enable_reg <= pwdata[7:0] & 8'h3F;
      end
      if (idx == IDX_SELECT) begin
        shared_source_selector <= pwdata[SELECT_BIT];
      end
      if (idx == IDX_MODE) begin
        slow_mode <= pwdata[MODE_SLOW_BIT];
      end
    end
  end

  // Sticky latches, write one to clear, a new hit wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= LATCH_RESET;
    end else begin
      latch <= (latch & ~clr) | hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= master_irq_enable & |(latch & enable_flags);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_master_gate: assert property (
    $rose(irq) |-> $past(master_irq_enable) && |$past(latch & enable_flags)
  ) else $error("interrupt rose without master enable");

  // input zero latch needs pin function
  chk_zero_pin_func: assert property (
    $rose(latch[SLOT_ZERO]) |-> $past(ext_irq_control.pin_func)
      && $past(fall[SLOT_ZERO])
  ) else $error("input zero latched without pin function");

  // input five only on falling edge
  chk_five_falling: assert property (
    $rose(latch[SLOT_FIVE]) |-> $past(fall[SLOT_FIVE])
  ) else $error("input five latched without falling edge");

  // input one follows its edge select
  chk_one_edge_sel: assert property (
    $rose(latch[SLOT_ONE]) |-> ($past(ext_irq_control.edge_one)
      ? $past(fall[SLOT_ONE]) : $past(rise[SLOT_ONE]))
  ) else $error("input one latched on wrong edge");

  // external edge ignored while timer selected
  chk_three_select: assert property (
    shared_source_selector && !timer_three_irq && !latch[SLOT_THREE]
      |=> !latch[SLOT_THREE]
  ) else $error("input three latched while timer selected");

  // Set wins over a clearing write
  chk_set_wins: assert property (
    (|(hit & clr)) |=> ((latch & $past(hit & clr)) == $past(hit & clr))
  ) else $error("latch lost an event during clear");

  // Bus answers in the first access cycle
  chk_apb_ready: assert property (
    setup |=> pready && psel && penable ##1 !pready
  ) else $error("ready not given in first access cycle");

  // input zero level falls only after two low samples
  chk_zero_reject: assert property (
    $fell(filt[SLOT_ZERO]) |-> !$past(g_filt[SLOT_ZERO].u_filt.sync_b)
      && !$past(g_filt[SLOT_ZERO].u_filt.sync_b, 2)
  ) else $error("input zero filter passed too early");

  cov_zero_latched: cover property ($rose(latch[SLOT_ZERO]));
  cov_irq_raised: cover property ($rose(irq));
  cov_slow_latch: cover property (slow_mode ##1 $rose(latch[SLOT_TWO]));
  cov_clear_latch: cover property ($fell(latch[SLOT_ONE]));

endmodule // eirqfe_top
`default_nettype wire

// ---- verification/eirqfe_src_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module eirqfe_src_model
  import eirqfe_pkg::*;
(
  // Sampling clock
  input wire logic pclk,
  // Pin levels, idle high
  output logic [NUM_IRQ-1:0] pins
);
  // Sources rest at the idle-high level
  initial begin
    pins = 5'h1F;
  end

  // Move one pin to a new level just after an edge
  task automatic step(input int slot, input logic lvl);
    @(posedge pclk);
    pins[slot] <= lvl;
  endtask

  task automatic pulse(input int slot, input int width);
    step(slot, 1'b0);
    repeat (width) @(posedge pclk);
    pins[slot] <= 1'b1;
  endtask
endmodule // eirqfe_src_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import eirqfe_pkg::*;
();
  typedef struct packed {
    logic mode;
    logic [2:0] slot;
    logic [7:0] ctrl;
    logic [7:0] width;
    logic hit;
  } eirqfe_row_type;

  // Bench signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_IRQ-1:0] pins;
  logic low_freq_clock = 1'b0;
  logic [3:0] lf_cnt = 4'h0;
  logic timer_three_irq = 1'b0;
  logic shared_port_bit;
  logic irq;
  int errors = 0;
  int cmp_count = 0;
  // Mode, slot, control, low pulse width, latch expected
  eirqfe_row_type rows [0:14] = '{
    '{1'b0, 3'h0, 8'h40, 8'h01, 1'b0},
    '{1'b0, 3'h0, 8'h40, 8'h07, 1'b1},
    '{1'b0, 3'h0, 8'h00, 8'h07, 1'b0},
    '{1'b0, 3'h4, 8'h00, 8'h01, 1'b0},
    '{1'b0, 3'h4, 8'h00, 8'h07, 1'b1},
    '{1'b0, 3'h1, 8'h80, 8'h0E, 1'b0},
    '{1'b0, 3'h1, 8'h80, 8'h31, 1'b1},
    '{1'b0, 3'h1, 8'h00, 8'h3E, 1'b0},
    '{1'b0, 3'h1, 8'h00, 8'hC1, 1'b1},
    '{1'b0, 3'h2, 8'h00, 8'h06, 1'b0},
    '{1'b0, 3'h2, 8'h00, 8'h19, 1'b1},
    '{1'b0, 3'h3, 8'h00, 8'h06, 1'b0},
    '{1'b0, 3'h3, 8'h00, 8'h19, 1'b1},
    '{1'b1, 3'h2, 8'h00, 8'h0F, 1'b0},
    '{1'b1, 3'h2, 8'h00, 8'h46, 1'b1}
  };

  eirqfe_top #(.CNT_W(7)) eirqfe_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pins(pins), .low_freq_clock(low_freq_clock),
    .timer_three_irq(timer_three_irq), .shared_port_bit(shared_port_bit),
    .irq(irq));
  eirqfe_src_model eirqfe_src_model_i (.pclk(pclk), .pins(pins));

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  // Low-frequency clock, period of 20 pclk cycles
  always @(posedge pclk) begin
    lf_cnt <= lf_cnt + 4'h1;
    if (lf_cnt == 4'h9) begin
      lf_cnt <= 4'h0;
      low_freq_clock <= ~low_freq_clock;
    end
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; returns error flag above read data
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] d, output logic [32:0] rsp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rsp = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, idx, 32'h0000_0000, r);
    check(r, exp);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, {32'h0, exp});
  endtask

  task automatic timer_pulse;
    @(posedge pclk);
    timer_three_irq <= 1'b1;
    @(posedge pclk);
    timer_three_irq <= 1'b0;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [32:0] exp_v;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check({32'h0, shared_port_bit}, 33'h1);
    check({32'h0, irq}, 33'h0);
    rd(IDX_CTRL, 33'h0);
    rd(IDX_ENABLE, 33'h0);
    rd(IDX_LATCH, 33'h0);
    rd(IDX_SELECT, 33'h0);
    rd(IDX_MODE, 33'h0);
    rd(10'h100, 33'h1_0000_0000);
    wr(IDX_CTRL, 32'h0000_00FF);
    rd(IDX_CTRL, 33'h0_0000_00CE);
    foreach (rows[i]) begin
      wr(IDX_ENABLE, 32'h0000_0000);
      wr(IDX_MODE, {31'h0, rows[i].mode});
      wr(IDX_CTRL, {24'h0, rows[i].ctrl});
      wr(IDX_LATCH, 32'h0000_003E);
      wr(IDX_ENABLE, 32'h0000_003F);
      eirqfe_src_model_i.pulse(rows[i].slot, rows[i].width);
      repeat (100) @(posedge pclk);
      exp_v = rows[i].hit ? (33'h1 << (rows[i].slot + 1)) : 33'h0;
      rd(IDX_LATCH, exp_v);
      check({32'h0, irq}, {32'h0, rows[i].hit});
    end
    wr(IDX_MODE, 32'h0000_0000);
    // Held level steps show which edge each select bit picks
    for (int s = 1; s <= 3; s++) begin
      for (int f = 0; f <= 1; f++) begin
        wr(IDX_ENABLE, 32'h0000_0000);
        wr(IDX_CTRL, 32'h0000_0080 | (32'(f) << s));
        wr(IDX_LATCH, 32'h0000_003E);
        eirqfe_src_model_i.step(s, 1'b0);
        repeat (40) @(posedge pclk);
        rd(IDX_LATCH, (f != 0) ? (33'h1 << (s + 1)) : 33'h0);
        eirqfe_src_model_i.step(s, 1'b1);
        repeat (40) @(posedge pclk);
        rd(IDX_LATCH, 33'h1 << (s + 1));
      end
    end
    // Input three latch is pending: flags without master stay silent
    wr(IDX_ENABLE, 32'h0000_003E);
    irq_is(1'b0);
    wr(IDX_ENABLE, 32'h0000_0001);
    irq_is(1'b0);
    wr(IDX_ENABLE, 32'h0000_0011);
    irq_is(1'b1);
    wr(IDX_LATCH, 32'h0000_0010);
    irq_is(1'b0);
    // Selector hands input three over to the timer source
    wr(IDX_SELECT, 32'h0000_0001);
    eirqfe_src_model_i.pulse(3, 25);
    repeat (40) @(posedge pclk);
    rd(IDX_LATCH, 33'h0);
    timer_pulse();
    irq_is(1'b1);
    wr(IDX_SELECT, 32'h0000_0000);
    wr(IDX_LATCH, 32'h0000_0010);
    timer_pulse();
    irq_is(1'b0);
    // Shared pin read as a port while its pin function is off
    wr(IDX_CTRL, 32'h0000_0000);
    eirqfe_src_model_i.step(0, 1'b0);
    repeat (20) @(posedge pclk);
    check({32'h0, shared_port_bit}, 33'h0);
    rd(IDX_LATCH, 33'h0);
    eirqfe_src_model_i.step(0, 1'b1);
    repeat (20) @(posedge pclk);
    check({32'h0, shared_port_bit}, 33'h1);
    // Reset in mid-run drops a pending request and the registers
    wr(IDX_SELECT, 32'h0000_0001);
    timer_pulse();
    irq_is(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    presetn <= 1'b1;
    rd(IDX_LATCH, 33'h0);
    rd(IDX_SELECT, 33'h0);
    rd(IDX_CTRL, 33'h0);
    check({32'h0, shared_port_bit}, 33'h1);
    conclude();
  end

  // Watchdog against a hang
  initial begin
    #400_000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
